// [design/aemi_alert_top.sv]
// alert event flags, alert masks and the active-low interrupt line
`timescale 1ns/100ps
// Notes on behaviour
// - interrupt line goes low when a flag is set and its mask bit is one
// - interrupt stays low while an unmasked flag is set; flags clear by writing one
// - interrupt returns high once no set flag remains unmasked
// - upper event byte lives at 0x11 and resets to zero
// - bit 7 sets while an unmasked vendor source is pending
// - bit 3 sets when supply crosses the sink disconnect threshold
// - bit 2 sets on receive overflow; writing one acknowledges it
// - overflow condition itself clears only by clearing receive status flag
// - bit 1 sets when any fault is recorded
// - bit 0 sets on supply low alarm
// - mask bit zero blocks its event, one lets it through
// - lower mask byte resets to all ones, one bit per lower event
// - upper mask bit 7 gates vendor events onto the interrupt
// - upper mask bits 3 to 0 gate upper events; reset value 0x0F
// - lower event byte at 0x10 holds the eight lower event flags
// - receive status flag sets only on buffer change with nonzero count
module aemi_alert_top (
    input wire logic clock_in,
    input wire logic rst_in,
    // register port from the serial register interface engine
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // event sources, one-cycle pulses from the detectors, except the levels rx_byte_count_nonzero_in and vendor_pending_in
    input wire logic channel_event_in,
    input wire logic power_event_in,
    input wire logic rx_buffer_changed_in,
    input wire logic rx_byte_count_nonzero_in,
    input wire logic hard_reset_event_in,
    input wire logic transmit_failed_in,
    input wire logic transmit_discarded_in,
    input wire logic transmit_success_in,
    input wire logic supply_high_alarm_in,
    input wire logic supply_low_alarm_in,
    input wire logic fault_recorded_in,
    input wire logic receive_overflow_in,
    input wire logic sink_disconnect_event_in,
    // level: some vendor source is set and unmasked in its own mask
    input wire logic vendor_pending_in,
    // outputs
    output logic int_n_out,
    output logic overflow_active_out
);
    logic [7:0] lower_set;
    logic [7:0] lower_clear;
    logic [7:0] lower_flags;
    logic [7:0] upper_set;
    logic [7:0] upper_clear;
    logic [7:0] upper_flags;

    logic [7:0] mask_lower_reg;
    logic [7:0] mask_lower_next;
    logic [7:0] mask_upper_reg;
    logic [7:0] mask_upper_next;
    logic overflow_reg;
    logic overflow_next;
    logic int_n_reg;
    logic int_n_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    logic wr_lower_events;
    logic wr_upper_events;
    logic wr_mask_lower;
    logic wr_mask_upper;

    // address decode
    always_comb begin
        wr_lower_events = reg_wr_in && (reg_addr_in == aemi_pkg::AEMI_EVENTS_LOWER_OFS);
        wr_upper_events = reg_wr_in && (reg_addr_in == aemi_pkg::AEMI_EVENTS_UPPER_OFS);
        wr_mask_lower = reg_wr_in && (reg_addr_in == aemi_pkg::AEMI_MASK_LOWER_OFS);
        wr_mask_upper = reg_wr_in && (reg_addr_in == aemi_pkg::AEMI_MASK_UPPER_OFS);
    end

    // event sources mapped onto flag positions
    always_comb begin
        lower_set = 8'h00;
        lower_set[aemi_pkg::AEMI_LO_CHANNEL] = channel_event_in;
        lower_set[aemi_pkg::AEMI_LO_POWER] = power_event_in;
        lower_set[aemi_pkg::AEMI_LO_RX_STATUS] =
            rx_buffer_changed_in && rx_byte_count_nonzero_in;
        lower_set[aemi_pkg::AEMI_LO_HARD_RESET] = hard_reset_event_in;
        lower_set[aemi_pkg::AEMI_LO_TX_FAILED] = transmit_failed_in;
        lower_set[aemi_pkg::AEMI_LO_TX_DISCARDED] = transmit_discarded_in;
        lower_set[aemi_pkg::AEMI_LO_TX_SUCCESS] = transmit_success_in;
        lower_set[aemi_pkg::AEMI_LO_SUPPLY_HIGH] = supply_high_alarm_in;
        lower_clear = wr_lower_events ? reg_wdata_in : 8'h00;

        upper_set = 8'h00;
        upper_set[aemi_pkg::AEMI_UP_SUPPLY_LOW] = supply_low_alarm_in;
        upper_set[aemi_pkg::AEMI_UP_FAULT] = fault_recorded_in;
        upper_set[aemi_pkg::AEMI_UP_RX_OVERFLOW] = receive_overflow_in;
        upper_set[aemi_pkg::AEMI_UP_SINK_DISCONNECT] = sink_disconnect_event_in;
        // vendor summary follows a pending vendor source; clear the source before this bit
        upper_set[aemi_pkg::AEMI_UP_VENDOR] = vendor_pending_in;
        upper_clear = wr_upper_events ? (reg_wdata_in & aemi_pkg::AEMI_UPPER_IMPL) : 8'h00;
    end

    aemi_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(aemi_pkg::AEMI_EVENTS_LOWER_RST),
        .IMPL_MASK(8'hFF)
    ) u_lower_flags (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .set_in(lower_set),
        .clear_in(lower_clear),
        .flags_out(lower_flags)
    );

    aemi_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(aemi_pkg::AEMI_EVENTS_UPPER_RST),
        .IMPL_MASK(aemi_pkg::AEMI_UPPER_IMPL)
    ) u_upper_flags (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .set_in(upper_set),
        .clear_in(upper_clear),
        .flags_out(upper_flags)
    );

    // masks and underlying overflow condition
    always_comb begin
        mask_lower_next = mask_lower_reg;
        mask_upper_next = mask_upper_reg;
        if (wr_mask_lower) begin
            mask_lower_next = reg_wdata_in;
        end
        if (wr_mask_upper) begin
            mask_upper_next = reg_wdata_in & aemi_pkg::AEMI_UPPER_IMPL;
        end
        overflow_next = overflow_reg;
        if (receive_overflow_in) begin
            overflow_next = 1'b1;
        end else if (wr_lower_events && reg_wdata_in[aemi_pkg::AEMI_LO_RX_STATUS]) begin
            // acknowledging the upper overflow bit alone leaves this set
            overflow_next = 1'b0;
        end
    end

    // interrupt line: low while any set flag is enabled by its mask bit
    always_comb begin
        int_n_next = ~(|(lower_flags & mask_lower_reg)
            | |(upper_flags & mask_upper_reg & aemi_pkg::AEMI_UPPER_IMPL));
    end

    // read path, unmapped offsets read zero
    always_comb begin
        rvalid_next = reg_rd_in;
        rdata_next = rdata_reg;
        if (reg_rd_in) begin
            case (reg_addr_in)
                aemi_pkg::AEMI_EVENTS_LOWER_OFS: begin
                    rdata_next = lower_flags;
                end
                aemi_pkg::AEMI_EVENTS_UPPER_OFS: begin
                    rdata_next = upper_flags & aemi_pkg::AEMI_UPPER_IMPL;
                end
                aemi_pkg::AEMI_MASK_LOWER_OFS: begin
                    rdata_next = mask_lower_reg;
                end
                aemi_pkg::AEMI_MASK_UPPER_OFS: begin
                    rdata_next = mask_upper_reg & aemi_pkg::AEMI_UPPER_IMPL;
                end
                default: begin
                    rdata_next = aemi_pkg::AEMI_READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mask_lower_reg <= aemi_pkg::AEMI_MASK_LOWER_RST;
            mask_upper_reg <= aemi_pkg::AEMI_MASK_UPPER_RST;
            overflow_reg <= 1'b0;
            int_n_reg <= 1'b1;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            mask_lower_reg <= mask_lower_next;
            mask_upper_reg <= mask_upper_next;
            overflow_reg <= overflow_next;
            int_n_reg <= int_n_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign int_n_out = int_n_reg;
    assign overflow_active_out = overflow_reg;
    assign reg_rdata_out = rdata_reg;
    assign reg_rvalid_out = rvalid_reg;
endmodule : aemi_alert_top

// [inc/aemi_pkg.sv]
// constants shared by the alert event and mask block
package aemi_pkg;
    localparam int unsigned AEMI_DATA_W = 8;
    localparam int unsigned AEMI_ADDR_W = 8;

    // register offsets
    localparam logic [7:0] AEMI_EVENTS_LOWER_OFS = 8'h10;
    localparam logic [7:0] AEMI_EVENTS_UPPER_OFS = 8'h11;
    localparam logic [7:0] AEMI_MASK_LOWER_OFS = 8'h12;
    localparam logic [7:0] AEMI_MASK_UPPER_OFS = 8'h13;

    // values after reset, and the value read at unmapped offsets
    localparam logic [7:0] AEMI_EVENTS_LOWER_RST = 8'h00;
    localparam logic [7:0] AEMI_EVENTS_UPPER_RST = 8'h00;
    localparam logic [7:0] AEMI_MASK_LOWER_RST = 8'hFF;
    localparam logic [7:0] AEMI_MASK_UPPER_RST = 8'h0F;
    localparam logic [7:0] AEMI_READ_UNMAPPED = 8'h00;

    // implemented bits of the upper bytes; bits 6 to 4 are reserved
    localparam logic [7:0] AEMI_UPPER_IMPL = 8'h8F;

    // lower event byte bit positions
    localparam int unsigned AEMI_LO_CHANNEL = 0;
    localparam int unsigned AEMI_LO_POWER = 1;
    localparam int unsigned AEMI_LO_RX_STATUS = 2;
    localparam int unsigned AEMI_LO_HARD_RESET = 3;
    localparam int unsigned AEMI_LO_TX_FAILED = 4;
    localparam int unsigned AEMI_LO_TX_DISCARDED = 5;
    localparam int unsigned AEMI_LO_TX_SUCCESS = 6;
    localparam int unsigned AEMI_LO_SUPPLY_HIGH = 7;

    // upper event byte bit positions
    localparam int unsigned AEMI_UP_SUPPLY_LOW = 0;
    localparam int unsigned AEMI_UP_FAULT = 1;
    localparam int unsigned AEMI_UP_RX_OVERFLOW = 2;
    localparam int unsigned AEMI_UP_SINK_DISCONNECT = 3;
    localparam int unsigned AEMI_UP_VENDOR = 7;
endpackage : aemi_pkg

// [design/aemi_flag_bank.sv]
// bank of sticky event flags, set by hardware, cleared by writing one
`timescale 1ns/100ps
module aemi_flag_bank #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] flags_out
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            always_comb begin
                if (!IMPL_MASK[i]) begin
                    flags_next[i] = 1'b0;
                end else if (set_in[i]) begin
                    flags_next[i] = 1'b1; // set wins over a clear in the same cycle
                end else if (clear_in[i]) begin
                    flags_next[i] = 1'b0;
                end else begin
                    flags_next[i] = flags_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flags_reg <= RESET_VALUE;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags_out = flags_reg;
endmodule : aemi_flag_bank

// [dv/aemi_alert_properties.sv]
// assertions on the alert block ports
`timescale 1ns/100ps
module aemi_alert_properties (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic channel_event_in,
    input wire logic supply_low_alarm_in,
    input wire logic fault_recorded_in,
    input wire logic receive_overflow_in,
    input wire logic sink_disconnect_event_in,
    input wire logic vendor_pending_in,
    input wire logic int_n_out,
    input wire logic overflow_active_out
);
    logic [7:0] mlo_reg;
    logic [7:0] mlo_next;
    logic [7:0] mhi_reg;
    logic [7:0] mhi_next;
    logic [3:0] ev4;
    logic clr_ovf;
    assign ev4 = {sink_disconnect_event_in, receive_overflow_in, fault_recorded_in,
        supply_low_alarm_in};
    assign clr_ovf = reg_wr_in && reg_addr_in == 8'h10 && reg_wdata_in[2];
    // shadow of both mask bytes
    always_comb begin
        mlo_next = (reg_wr_in && reg_addr_in == 8'h12) ? reg_wdata_in : mlo_reg;
        mhi_next = (reg_wr_in && reg_addr_in == 8'h13) ? (reg_wdata_in & 8'h8F) : mhi_reg;
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mlo_reg <= 8'hFF;
            mhi_reg <= 8'h0F;
        end else begin
            mlo_reg <= mlo_next;
            mhi_reg <= mhi_next;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    AST_INT_LOW: assert property (channel_event_in && mlo_reg[0] && !reg_wr_in
        ##1 !reg_wr_in |=> !int_n_out) else $error("interrupt not asserted");
    AST_INT_HOLD: assert property (!int_n_out && !$past(reg_wr_in) |=> !int_n_out)
        else $error("interrupt dropped without a write");
    AST_INT_RELEASE: assert property (mlo_reg == 8'h00 && mhi_reg == 8'h00
        |=> int_n_out) else $error("interrupt low with all masked");
    AST_EVENT_READ: assert property ((ev4 != 4'h0)
        ##1 (reg_rd_in && reg_addr_in == 8'h11)
        |=> (reg_rdata_out[3:0] & $past(ev4, 2)) == $past(ev4, 2))
        else $error("upper flag missing");
    AST_VENDOR_READ: assert property (vendor_pending_in
        ##1 (reg_rd_in && reg_addr_in == 8'h11) |=> reg_rdata_out[7])
        else $error("vendor summary missing");
    AST_RSVD_READ: assert property (reg_rd_in && reg_addr_in inside {8'h11, 8'h13}
        |=> reg_rvalid_out && reg_rdata_out[6:4] == 3'h0) else $error("reserved bits not zero");
    AST_OVF_SET: assert property (receive_overflow_in |=> overflow_active_out)
        else $error("overflow not raised");
    AST_OVF_HOLD: assert property (overflow_active_out && !clr_ovf |=> overflow_active_out)
        else $error("overflow dropped early");
    AST_OVF_CLEAR: assert property (clr_ovf && !receive_overflow_in |=> !overflow_active_out)
        else $error("overflow not cleared");
endmodule : aemi_alert_properties
bind aemi_alert_top aemi_alert_properties i_props (.*);

// [dv/aemi_host_model.sv]
// port manager host model on the register port
`timescale 1ns/100ps
module aemi_host_model (
    input wire logic clock_in,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(posedge clock_in);
        #1;
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        #1;
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(posedge clock_in);
        #1;
        reg_rd_out = 1'b0;
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
    endtask : rd
endmodule : aemi_host_model

// [dv/tb_top.sv]
// self-checking bench of the alert event and mask block
`timescale 1ns/100ps
module tb_top;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [12:0] ev = 13'h0000;
    logic nz = 1'b1;
    logic [7:0] addr, wdata, rdata, got, b, m;
    logic wr, rd, rvalid, int_n, ovf, en;
    logic [15:0] lfsr = 16'h93D8;
    int err_total = 0;
    int n_tests = 0;
    int i;
    always #25 clock_in = ~clock_in;
    aemi_host_model i_host (.clock_in(clock_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
        .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd));
    aemi_alert_top i_dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .channel_event_in(ev[0]), .power_event_in(ev[1]),
        .rx_buffer_changed_in(ev[2]), .rx_byte_count_nonzero_in(nz),
        .hard_reset_event_in(ev[3]), .transmit_failed_in(ev[4]),
        .transmit_discarded_in(ev[5]), .transmit_success_in(ev[6]),
        .supply_high_alarm_in(ev[7]), .supply_low_alarm_in(ev[8]),
        .fault_recorded_in(ev[9]), .receive_overflow_in(ev[10]),
        .sink_disconnect_event_in(ev[11]), .vendor_pending_in(ev[12]),
        .int_n_out(int_n), .overflow_active_out(ovf));
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step
    function automatic logic [7:0] ev_bit(input int k);
        return k < 8 ? 8'h01 << k : (k == 12 ? 8'h80 : 8'h01 << (k - 8));
    endfunction : ev_bit
    function automatic logic [7:0] ev_addr(input int k);
        return k < 8 ? 8'h10 : 8'h11;
    endfunction : ev_addr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // vendor source is a level and stays up after the pulse
    task automatic pulse(input int k);
        ev[k] = 1'b1;
        @(posedge clock_in);
        #1;
        ev[k] = (k == 12);
    endtask : pulse
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        chk({6'h00, int_n, ovf}, 8'h02);
        for (int a = 16; a < 21; a++) begin
            i_host.rd(a[7:0], got);
            chk(got, a == 18 ? 8'hFF : (a == 19 ? 8'h0F : 8'h00));
        end
        // a write to an unmapped offset must leave the lower mask alone
        i_host.wr(8'h14, 8'h00);
        i_host.rd(8'h12, got);
        chk(got, 8'hFF);
        i_host.wr(8'h13, 8'hFF);
        i_host.wr(8'h11, 8'h70);
        i_host.rd(8'h13, got);
        chk(got, 8'h8F);
        i_host.rd(8'h11, got);
        chk(got, 8'h00);
        nz = 1'b0;
        pulse(2);
        nz = 1'b1;
        i_host.rd(8'h10, got);
        chk(got, 8'h00);
        // upper events read back in the cycle right after they fire
        ev[11:8] = 4'hF;
        i_host.rd(8'h11, got);
        ev[11:8] = 4'h0;
        chk(got, 8'h0F);
        chk({7'h00, int_n}, 8'h00);
        i_host.wr(8'h11, 8'h0F);
        i_host.wr(8'h10, 8'h04);
        // an event in the cycle of its clear keeps the flag set
        ev[0] = 1'b1;
        i_host.wr(8'h10, 8'h01);
        ev[0] = 1'b0;
        i_host.rd(8'h10, got);
        chk(got, 8'h01);
        // vendor summary comes back while the source is still pending
        ev[12] = 1'b1;
        i_host.wr(8'h11, 8'h80);
        i_host.rd(8'h11, got);
        chk(got, 8'h80);
        ev[12] = 1'b0;
        i_host.wr(8'h11, 8'h80);
        i_host.wr(8'h10, 8'h01);
        i_host.rd(8'h10, got);
        chk(got, 8'h00);
        i_host.rd(8'h11, got);
        chk(got, 8'h00);
        for (int k = 0; k < 39; k++) begin
            i = k % 13;
            lfsr = lfsr_step(lfsr);
            b = ev_bit(i);
            en = lfsr[8];
            m = en ? (lfsr[7:0] | b) : 8'h00;
            i_host.wr(ev_addr(i) + 8'h02, m);
            i_host.wr((ev_addr(i) + 8'h02) ^ 8'h01, en ? lfsr[15:8] : 8'h00);
            pulse(i);
            repeat (3) @(posedge clock_in);
            #1;
            chk({7'h00, int_n}, {7'h00, !en});
            i_host.rd(ev_addr(i), got);
            chk(got, b);
            ev[12] = 1'b0;
            i_host.wr(ev_addr(i), b);
            repeat (3) @(posedge clock_in);
            #1;
            chk({7'h00, int_n}, 8'h01);
            i_host.rd(ev_addr(i), got);
            chk(got, 8'h00);
            chk({7'h00, ovf}, {7'h00, i == 10});
            i_host.wr(8'h10, 8'h04);
            chk({7'h00, ovf}, 8'h00);
        end
        final_report();
    end
endmodule : tb_top
